// >>> verilog/sub_defines.svh
// Notes on behaviour
// - Literal subtract stores immediate minus working register there.
// - File subtract computes file operand minus working register.
// - Destination bit zero sends the difference to working register.
// - Destination bit one writes the difference back to the file.
// - Carry clears when the minuend is smaller than working register.
// - Carry sets when the difference is positive.
// - Carry sets when the difference is exactly zero.
`ifndef SUB_DEFINES_SVH
`define SUB_DEFINES_SVH
`define SUB_OPCODE_MSB 13
`define SUB_OP_LIT_HI 5
`define SUB_OP_LIT_VAL 5'h1E
`define SUB_OP_FILE_HI 6
`define SUB_OP_FILE_VAL 6'h02
`define SUB_DEST_BIT 7
`define SUB_LIT_MSB 7
`define SUB_FILE_ADDR_MSB 6
`define SUB_W_RESET 8'h00
`define SUB_FILE_RESET 8'h00
`define SUB_WB_ADDR_INSN 4'h0
`define SUB_WB_ADDR_WREG 4'h4
`define SUB_WB_ADDR_STATUS 4'h8
`define SUB_WB_ADDR_FILE 4'hC
`define SUB_STAT_C 0
`define SUB_STAT_DC 1
`define SUB_STAT_Z 2
`endif

// >>> verilog/sub_pkg.sv
`default_nettype none
package sub_pkg;
    typedef struct packed {
        logic zero;
        logic digit_carry_flag;
        logic carry;
    } sub_flags_type;
    typedef struct packed {
        logic [7:0] value;
        logic write_file;
        logic [6:0] addr;
    } sub_file_wr_type;
endpackage
`default_nettype wire

// >>> verilog/sub_datapath.sv
// The Wishbone interface to the registers and the placing of the registers were decided locally.
`include "sub_defines.svh"
`default_nettype none
module sub_datapath
    import sub_pkg::*;
#(
    parameter int DATA_WIDTH = 8,
    parameter int INSN_WIDTH = 14
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    output logic [7:0] w_o,
    output sub_flags_type flags_o,
    output sub_file_wr_type file_wr_o
);
    generate
        if (DATA_WIDTH != 8 || INSN_WIDTH != 14) begin : g_bad_width
            $error("Only 8-bit data and 14-bit instructions are served.");
        end
    endgenerate

    logic [13:0] insn;
    logic [7:0] minuend;
    logic [8:0] diff9;
    logic [4:0] low5;
    wire logic [7:0] chain_diff;
    wire logic [8:0] borrow;
    logic is_lit;
    logic is_file;
    logic to_file;
    logic exec;
    logic req;
    logic wr_req;
    logic ack_reg;
    logic ack_next;
    logic [7:0] w_reg;
    logic [7:0] w_next;
    logic [7:0] file_val_reg;
    logic [7:0] file_val_next;
    sub_flags_type flags_reg;
    sub_flags_type flags_next;
    sub_file_wr_type wr_reg;
    sub_file_wr_type wr_next;
    logic [31:0] rd_data;
    logic [31:0] dat_reg;
    logic [31:0] dat_next;

    assign req = wb_cyc_i && wb_stb_i && !ack_reg;
    assign wr_req = req && wb_we_i && wb_sel_i[0];
    assign insn = wb_dat_i[13:0];
    assign is_lit = insn[`SUB_OPCODE_MSB -: `SUB_OP_LIT_HI]
        == `SUB_OP_LIT_VAL;
    assign is_file = insn[`SUB_OPCODE_MSB -: `SUB_OP_FILE_HI]
        == `SUB_OP_FILE_VAL;
    assign exec = wr_req && wb_sel_i[1]
        && wb_adr_i == `SUB_WB_ADDR_INSN && (is_lit || is_file);
    assign to_file = is_file && insn[`SUB_DEST_BIT];
    assign minuend = is_lit ? insn[`SUB_LIT_MSB:0]
        : file_val_reg;
    assign diff9 = {1'b0, minuend} - {1'b0, w_reg};
    assign low5 = {1'b0, minuend[3:0]} - {1'b0, w_reg[3:0]};

    // Ripple borrow chain; the nibble borrow feeds digit carry.
    assign borrow[0] = 1'b0;
    for (genvar i = 0; i < DATA_WIDTH; i++) begin : g_bit
        assign chain_diff[i] = minuend[i] ^ w_reg[i] ^ borrow[i];
        assign borrow[i + 1] = (!minuend[i] && w_reg[i])
            || (!(minuend[i] ^ w_reg[i]) && borrow[i]);
        AST_BIT_SUM: assert property (
            @(posedge clk_i) disable iff (rst_i)
            chain_diff[i] == diff9[i])
            else $error("Borrow chain bit disagrees with the difference.");
    end

    always_comb begin
        ack_next = req;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= ack_next;
        end
    end

    always_comb begin
        w_next = w_reg;
        if (wr_req && wb_adr_i == `SUB_WB_ADDR_WREG) begin
            w_next = wb_dat_i[7:0];
        end
        if (exec && !to_file) begin
            w_next = chain_diff;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            w_reg <= `SUB_W_RESET;
        end else begin
            w_reg <= w_next;
        end
    end

    always_comb begin
        file_val_next = file_val_reg;
        if (wr_req && wb_adr_i == `SUB_WB_ADDR_FILE) begin
            file_val_next = wb_dat_i[7:0];
        end
        if (exec && to_file) begin
            file_val_next = chain_diff;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            file_val_reg <= `SUB_FILE_RESET;
        end else begin
            file_val_reg <= file_val_next;
        end
    end

    always_comb begin
        flags_next = flags_reg;
        if (wr_req && wb_adr_i == `SUB_WB_ADDR_STATUS) begin
            flags_next.carry = wb_dat_i[`SUB_STAT_C];
            flags_next.digit_carry_flag = wb_dat_i[`SUB_STAT_DC];
            flags_next.zero = wb_dat_i[`SUB_STAT_Z];
        end
        if (exec) begin
            flags_next.carry = !borrow[DATA_WIDTH];
            flags_next.digit_carry_flag = !borrow[DATA_WIDTH / 2];
            flags_next.zero = chain_diff == 8'h00;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= flags_next;
        end
    end

    always_comb begin
        wr_next = wr_reg;
        wr_next.write_file = 1'b0;
        if (exec && to_file) begin
            wr_next.write_file = 1'b1;
            wr_next.value = chain_diff;
            wr_next.addr = insn[`SUB_FILE_ADDR_MSB:0];
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_reg <= '0;
        end else begin
            wr_reg <= wr_next;
        end
    end

    always_comb begin
        rd_data = 32'h0000_0000;
        case (wb_adr_i)
            `SUB_WB_ADDR_WREG: rd_data = {24'h00_0000, w_reg};
            `SUB_WB_ADDR_FILE: rd_data = {24'h00_0000, file_val_reg};
            `SUB_WB_ADDR_STATUS: rd_data = {29'h0000_0000, flags_reg.zero,
                flags_reg.digit_carry_flag, flags_reg.carry};
            default: rd_data = 32'h0000_0000;
        endcase
    end

    always_comb begin
        dat_next = rd_data;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_reg <= 32'h0000_0000;
        end else begin
            dat_reg <= dat_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_err_o = 1'b0;
    assign wb_dat_o = dat_reg;
    assign w_o = w_reg;
    assign flags_o = flags_reg;
    assign file_wr_o = wr_reg;

    AST_BORROW_CLEARS: assert property (
        @(posedge clk_i) disable iff (rst_i)
        exec && minuend < w_reg |=> !flags_reg.carry)
        else $error("Carry not cleared on borrow.");
    AST_POS_SETS: assert property (
        @(posedge clk_i) disable iff (rst_i)
        exec && minuend > w_reg |=> flags_reg.carry)
        else $error("Carry not set on positive difference.");
    AST_ZERO_SETS: assert property (
        @(posedge clk_i) disable iff (rst_i)
        exec && minuend == w_reg |=> flags_reg.carry && flags_reg.zero)
        else $error("Carry or zero wrong on equal operands.");
    AST_LIT_W: assert property (
        @(posedge clk_i) disable iff (rst_i)
        exec && is_lit |=> w_reg == $past(insn[7:0]) - $past(w_reg))
        else $error("Literal subtract result wrong.");
    AST_FILE_TO_W: assert property (
        @(posedge clk_i) disable iff (rst_i)
        exec && is_file && !insn[7] |=> !file_wr_o.write_file
        && w_reg == $past(file_val_reg) - $past(w_reg))
        else $error("File subtract to working register wrong.");
    AST_FILE_TO_F: assert property (
        @(posedge clk_i) disable iff (rst_i)
        exec && is_file && insn[7] |=> file_wr_o.write_file
        && $stable(w_reg) && file_wr_o.addr == $past(insn[6:0]))
        else $error("File subtract write-back wrong.");
    AST_FILE_VAL: assert property (
        @(posedge clk_i) disable iff (rst_i)
        exec && is_file |=> flags_reg.zero == ($past(file_val_reg)
        == $past(w_reg)))
        else $error("File subtract zero flag wrong.");
    AST_DC: assert property (
        @(posedge clk_i) disable iff (rst_i)
        exec |=> flags_reg.digit_carry_flag
        == ($past(minuend[3:0]) >= $past(w_reg[3:0])))
        else $error("Digit carry wrong.");
    AST_ACK_ONE: assert property (
        @(posedge clk_i) disable iff (rst_i)
        req |=> wb_ack_o)
        else $error("Acknowledge missing after a request.");
    AST_ACK_PULSE: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("Acknowledge held longer than one cycle.");
    AST_LIT_NO_WB: assert property (
        @(posedge clk_i) disable iff (rst_i)
        exec && is_lit |=> !file_wr_o.write_file
        && $stable(file_val_reg))
        else $error("Literal subtract touched the file operand.");
    AST_FILE_W_KEEP: assert property (
        @(posedge clk_i) disable iff (rst_i)
        exec && is_file && !insn[`SUB_DEST_BIT]
        |=> $stable(file_val_reg))
        else $error("File operand changed with destination zero.");
    AST_FILE_WB_VAL: assert property (
        @(posedge clk_i) disable iff (rst_i)
        exec && to_file |=> file_wr_o.value == $past(minuend) - $past(w_reg)
        && file_val_reg == file_wr_o.value)
        else $error("Write-back value wrong.");
    AST_WB_PULSE: assert property (
        @(posedge clk_i) disable iff (rst_i)
        file_wr_o.write_file |=> !file_wr_o.write_file)
        else $error("Write-back strobe longer than one cycle.");
    AST_NOP_HOLD: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wr_req && wb_sel_i[1] && wb_adr_i == `SUB_WB_ADDR_INSN && !is_lit
        && !is_file |=> $stable(w_reg) && $stable(flags_reg))
        else $error("Other opcode changed working register or flags.");
    AST_LIT_ZERO: assert property (
        @(posedge clk_i) disable iff (rst_i)
        exec && is_lit |=> flags_reg.zero
        == ($past(insn[7:0]) == $past(w_reg)))
        else $error("Literal subtract zero flag wrong.");
    AST_RESET_CLEAR: assert property (
        @(posedge clk_i)
        rst_i |=> w_reg == 8'h00 && flags_reg == 3'h0 && !wb_ack_o
        && !file_wr_o.write_file)
        else $error("State not cleared by reset.");
    AST_CARRY_BORROW: assert property (
        @(posedge clk_i) disable iff (rst_i)
        exec |=> flags_reg.carry == !$past(diff9[8]))
        else $error("Carry disagrees with the wide difference.");
    AST_LIT_CARRY: assert property (
        @(posedge clk_i) disable iff (rst_i)
        exec && is_lit |=> flags_reg.carry
        == ($past(insn[7:0]) >= $past(w_reg)))
        else $error("Literal subtract carry wrong.");
    AST_FILE_CARRY: assert property (
        @(posedge clk_i) disable iff (rst_i)
        exec && is_file |=> flags_reg.carry
        == ($past(file_val_reg) >= $past(w_reg)))
        else $error("File subtract carry wrong.");
    AST_IDLE_HOLD: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !exec && !wr_req |=> $stable(w_reg) && $stable(flags_reg)
        && $stable(file_val_reg))
        else $error("State changed without a request.");
    AST_DC_LIT: assert property (
        @(posedge clk_i) disable iff (rst_i)
        exec && is_lit |=> flags_reg.digit_carry_flag
        == ($past(insn[3:0]) >= $past(w_reg[3:0])))
        else $error("Literal subtract digit carry wrong.");
    AST_ZERO_CLR: assert property (
        @(posedge clk_i) disable iff (rst_i)
        exec && minuend != w_reg |=> !flags_reg.zero)
        else $error("Zero flag set on a nonzero difference.");
    AST_EXEC_ACK: assert property (
        @(posedge clk_i) disable iff (rst_i)
        exec |=> wb_ack_o)
        else $error("Instruction write not acknowledged.");
endmodule
`default_nettype wire

// >>> test/tb.sv
`default_nettype none
module tb
    import sub_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack;
    logic [3:0] adr = 4'h0;
    logic [3:0] sel = 4'hF;
    logic [31:0] dat = 32'h0, rd, q;
    logic [7:0] w;
    sub_flags_type fl;
    sub_file_wr_type fw, fwc;
    int num_errors = 0, comparisons = 0;
    sub_datapath u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack), .wb_err_o(),
        .w_o(w), .flags_o(fl), .file_wr_o(fw));
    initial forever #50 clk_i = ~clk_i;
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            num_errors++;
            $display("[FAIL] %0t seen %h exp %h", $time, s, e);
        end
    endtask
    // One classic cycle; read data and the write-back strobe are taken at ack.
    task automatic bus(input logic wr, input logic [3:0] a,
        input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= wr;
        adr <= a;
        dat <= d;
        @(posedge clk_i);
        while (ack !== 1'b1) @(posedge clk_i);
        q = rd;
        fwc = fw;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic run(input logic [13:0] op, input logic [7:0] wv, fv);
        logic [7:0] m, df;
        logic [2:0] ef;
        logic tof;
        tof = op[13:12] != 2'b11 && op[7];
        m = op[13:12] == 2'b11 ? op[7:0] : fv;
        df = m - wv;
        ef = {df == 8'h00, m[3:0] >= wv[3:0], m >= wv};
        bus(1'b1, 4'h4, {24'h0, wv});
        bus(1'b1, 4'hC, {24'h0, fv});
        bus(1'b1, 4'h0, {18'h0, op});
        chk(w, tof ? wv : df);
        chk(fl, ef);
        chk(fwc.write_file, tof);
        if (tof) chk({fwc.addr, fwc.value}, {op[6:0], df});
        bus(1'b0, 4'hC, 32'h0);
        chk(q[7:0], tof ? df : fv);
        bus(1'b0, 4'h8, 32'h0);
        chk(q[2:0], ef);
    endtask
    task automatic test_literal();
        run(14'h3C02, 8'h01, 8'h00);
        run(14'h3C02, 8'h02, 8'h00);
        run(14'h3C02, 8'h03, 8'h00);
        run(14'h3D20, 8'h01, 8'h55);
        run(14'h3DFF, 8'hFF, 8'h00);
        $display("test literal done");
    endtask
    task automatic test_file();
        run(14'h0205, 8'h02, 8'h03);
        run(14'h02FF, 8'h02, 8'h01);
        run(14'h02AA, 8'h02, 8'h02);
        run(14'h0280, 8'h01, 8'h10);
        run(14'h0200, 8'h80, 8'h7F);
        $display("test file done");
    endtask
    task automatic test_other();
        bus(1'b1, 4'h4, 32'h07);
        bus(1'b1, 4'h0, 32'h3E05);
        chk(w, 8'h07);
        chk(fwc.write_file, 1'b0);
        sel <= 4'h1;
        bus(1'b1, 4'h0, 32'h3C00);
        sel <= 4'hF;
        chk(w, 8'h07);
        bus(1'b0, 4'h2, 32'h0);
        chk(q, 32'h0);
        $display("test other done");
    endtask
    task automatic test_reset();
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk({w, fl, fw, ack}, 32'h0);
        bus(1'b0, 4'h4, 32'h0);
        chk(q, 32'h0);
        $display("test reset done");
    endtask
    task automatic wrap_up();
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (2000) @(posedge clk_i);
        num_errors++;
        wrap_up();
    end
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk({w, fl, fw}, 32'h0);
        test_literal();
        test_file();
        test_reset();
        test_other();
        wrap_up();
    end
endmodule
`default_nettype wire
